// ===== core/lma_pkg.sv
// constants and types for the long-mode operand addressing block
// Functional notes
// - sixteen 64-bit general registers in 64-bit mode
// - outside 64-bit mode eight 32-bit registers
// - flags upper half reads zero, lower accessible
// - 64-bit instruction pointer in long mode
// - stack pointer always 64 bits in 64-bit mode
// - control registers full width only in 64-bit
// - page enable toggles long mode when enabled
// - debug registers full width only in 64-bit; 8-15 unsupported
// - enable and active bits accessible in all modes
// - range registers read masked to PADDR_W bits every mode
// - physical-address registers read whole in any mode
// - extension prefix ignored where it means nothing
// - near branches and stack ops default 64-bit
// - data/extra/stack/code overrides become null prefixes
// - remaining two overrides add their segment base
// - default 32, extension 64, 66 gives 16
// - 32-bit results zero-extend, narrower preserve upper
// - address default 64, prefix gives 32, no 16
// - displacements sign-extended from 32 except move forms
// - addresses truncated to size then zero-extended
// - pointer-relative address is displacement plus next pointer
// - long code attribute in compatibility enters 64-bit
package lma_pkg;
	typedef enum logic [1:0] {MODE_LEGACY, MODE_COMPAT, MODE_64} lma_mode_t;
	typedef enum logic [1:0] {SZ_16, SZ_32, SZ_64, SZ_8} lma_size_t;
	// ========================================
	// register offsets
	localparam logic [7:0] OFF_CTRL  = 8'h00;
	localparam logic [7:0] OFF_STAT  = 8'h04;
	localparam logic [7:0] OFF_DEC   = 8'h08;
	localparam logic [7:0] OFF_DISPL = 8'h0c;
	localparam logic [7:0] OFF_DISPH = 8'h10;
	localparam logic [7:0] OFF_WBL   = 8'h14;
	localparam logic [7:0] OFF_WBH   = 8'h18;
	localparam logic [7:0] OFF_WBGO  = 8'h1c;
	localparam logic [7:0] OFF_EAL   = 8'h20;
	localparam logic [7:0] OFF_EAH   = 8'h24;
	localparam logic [7:0] OFF_GPRL  = 8'h28;
	localparam logic [7:0] OFF_GPRH  = 8'h2c;
	localparam logic [7:0] OFF_IPL   = 8'h30;
	localparam logic [7:0] OFF_IPH   = 8'h34;
	localparam logic [7:0] OFF_FLGL  = 8'h38;
	localparam logic [7:0] OFF_FLGH  = 8'h3c;
	localparam logic [7:0] OFF_FSL   = 8'h40;
	localparam logic [7:0] OFF_FSH   = 8'h44;
	localparam logic [7:0] OFF_GSL   = 8'h48;
	localparam logic [7:0] OFF_GSH   = 8'h4c;
	localparam logic [7:0] OFF_SSEL  = 8'h50;
	localparam logic [7:0] OFF_SYSL  = 8'h54;
	localparam logic [7:0] OFF_SYSH  = 8'h58;
	// ========================================
	// control fields
	localparam int CTL_CSL = 0;
	localparam int CTL_CSD = 1;
	localparam int CTL_SSB = 2;
	// ========================================
	// decode word fields
	localparam int DEC_REXP = 0;
	localparam int DEC_REXW = 1;
	localparam int DEC_REXR = 2;
	localparam int DEC_REXB = 3;
	localparam int DEC_OPSZ = 4;
	localparam int DEC_ADSZ = 5;
	localparam int DEC_SEG  = 6;
	localparam int DEC_STK  = 9;
	localparam int DEC_NEAR = 10;
	localparam int DEC_FAR  = 11;
	localparam int DEC_RIPR = 12;
	localparam int DEC_MOV  = 13;
	localparam int DEC_BYTE = 14;
	localparam int DEC_REG  = 15;
	localparam int DEC_RM   = 18;
	localparam logic [2:0] SEG_ES = 3'h1;
	localparam logic [2:0] SEG_CS = 3'h2;
	localparam logic [2:0] SEG_SS = 3'h3;
	localparam logic [2:0] SEG_DS = 3'h4;
	localparam logic [2:0] SEG_FS = 3'h5;
	localparam logic [2:0] SEG_GS = 3'h6;
	localparam logic [3:0] SP_IDX = 4'h4;
	// ========================================
	// status fields
	localparam int ST_MODE = 0;
	localparam int ST_LMA  = 2;
	localparam int ST_OSZ  = 4;
	localparam int ST_ASZ  = 6;
	localparam int ST_SEG  = 8;
	localparam int ST_REG  = 9;
	localparam int ST_RM   = 13;
	localparam int ST_ERR  = 17;
	// ========================================
	// system register selects and bits
	localparam logic [4:0] SYS_CR0  = 5'h00;
	localparam logic [4:0] SYS_CR8  = 5'h08;
	localparam logic [4:0] SYS_EXTENDED_FEATURE_REGISTER = 5'h09;
	localparam logic [4:0] SYS_MEMORY_TYPE_RANGE_REG = 5'h0a;
	localparam logic [4:0] SYS_PMSR = 5'h0b;
	localparam logic [1:0] SYS_DBG  = 2'h2;
	localparam logic [1:0] SYS_XDBG = 2'h3;
	localparam int EXTENDED_FEATURE_REGISTER_LME = 8;
	localparam int EXTENDED_FEATURE_REGISTER_LMA = 10;
	localparam int PAGE_ENABLE_BIT   = 31;
	localparam logic [31:0] RST_CTRL  = 32'h0000_0002;
	localparam logic [31:0] RST_FLAGS = 32'h0000_0002;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== core/lma_agen.sv
// effective address generation
`timescale 1ns/1ps
module lma_agen
	import lma_pkg::*;
(
	// operands
	input  wire logic [63:0] base_i,
	input  wire logic [63:0] ip_i,
	input  wire logic [63:0] disp_i,
	input  wire logic        ip_rel_i,
	input  wire lma_size_t   asz_i,
	input  wire logic [63:0] seg_base_i,
	// result
	output logic      [63:0] ea_o
);
	logic [63:0] sum;
	logic [63:0] trunc;
	logic [63:0] lin;
	assign sum = (ip_rel_i ? ip_i : base_i) + disp_i;
	always_comb begin
		unique case (asz_i)
			SZ_16:   trunc = {48'h0, sum[15:0]};
			SZ_32:   trunc = {32'h0, sum[31:0]};
			default: trunc = sum;
		endcase
	end
	assign lin  = trunc + seg_base_i;
	assign ea_o = (asz_i == SZ_64) ? lin : {32'h0, lin[31:0]};
endmodule

// ===== core/lma_core.sv
// long-mode decode, register file and system registers
//
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module lma_core
	import lma_pkg::*;
#(
	parameter int AXI_AW = 8,
	parameter int PADDR_W = 52
)(
	// clock and reset
	input  wire logic              SYS_CLK_I,
	input  wire logic              RST_I,
	// axi write address
	input  wire logic [AXI_AW-1:0] S_AXI_AWADDR_I,
	input  wire logic              S_AXI_AWVALID_I,
	output logic                   S_AXI_AWREADY_O,
	// axi write data
	input  wire logic [31:0]       S_AXI_WDATA_I,
	input  wire logic [3:0]        S_AXI_WSTRB_I,
	input  wire logic              S_AXI_WVALID_I,
	output logic                   S_AXI_WREADY_O,
	// axi write response
	output logic [1:0]             S_AXI_BRESP_O,
	output logic                   S_AXI_BVALID_O,
	input  wire logic              S_AXI_BREADY_I,
	// axi read
	input  wire logic [AXI_AW-1:0] S_AXI_ARADDR_I,
	input  wire logic              S_AXI_ARVALID_I,
	output logic                   S_AXI_ARREADY_O,
	output logic [31:0]            S_AXI_RDATA_O,
	output logic [1:0]             S_AXI_RRESP_O,
	output logic                   S_AXI_RVALID_O,
	input  wire logic              S_AXI_RREADY_I,
	// mode
	output lma_mode_t              MODE_O,
	output logic                   LMA_O
);
	initial begin
		if (AXI_AW < 8 || PADDR_W < 32 || PADDR_W > 52)
			$error("lma_core: unsupported parameter");
	end

	// ========================================
	// state
	logic [63:0]       gpr_q [16];
	logic [63:0]       sys_q [32];
	logic [31:0]       ctrl_q, dec_q, dlo_q, dhi_q, wbl_q, wbh_q;
	logic [63:0]       ip_q, fs_q, gs_q;
	logic [31:0]       flg_q, shi_q;
	logic [4:0]        sel_q;
	logic              err_q;
	logic [AXI_AW-1:0] awa_q;
	logic [31:0]       wd_q;
	logic [3:0]        ws_q;
	logic              aw_ok_q, w_ok_q;
	logic              awr_q, wr_q, bv_q, arr_q, rv_q;
	logic [1:0]        br_q, rr_q;
	logic [31:0]       rd_q;
	lma_mode_t         mode_q;
	logic              lma_q;

	// ========================================
	// operating mode
	wire lma = sys_q[SYS_EXTENDED_FEATURE_REGISTER][EXTENDED_FEATURE_REGISTER_LME] &
		sys_q[SYS_CR0][PAGE_ENABLE_BIT];
	lma_mode_t mode;
	assign mode = !lma ? MODE_LEGACY :
		ctrl_q[CTL_CSL] ? MODE_64 : MODE_COMPAT;
	wire m64 = (mode == MODE_64);
	wire csd = ctrl_q[CTL_CSD];

	// ========================================
	// prefix and operand decode
	wire       register_extension_prefix   = m64 & dec_q[DEC_REXP];
	wire       rex_w = register_extension_prefix & dec_q[DEC_REXW];
	wire       p66   = dec_q[DEC_OPSZ];
	wire       p67   = dec_q[DEC_ADSZ];
	wire       stk   = dec_q[DEC_STK];
	wire       def64 = dec_q[DEC_NEAR] |
		(stk & ~dec_q[DEC_FAR]);
	wire [2:0] seg   = dec_q[DEC_SEG+:3];
	wire [3:0] rix   = {register_extension_prefix & dec_q[DEC_REXR],
		dec_q[DEC_REG+:3]};
	wire [3:0] bix   = stk ? SP_IDX :
		{register_extension_prefix & dec_q[DEC_REXB], dec_q[DEC_RM+:3]};
	lma_size_t osz, asz;
	always_comb begin
		if (dec_q[DEC_BYTE])
			osz = SZ_8;
		else if (m64 && rex_w)
			osz = SZ_64;
		else if (m64 && p66)
			osz = SZ_16;
		else if (m64)
			osz = def64 ? SZ_64 : SZ_32;
		else
			osz = (csd ^ p66) ? SZ_32 : SZ_16;
	end
	always_comb begin
		if (m64)
			asz = (p67 & ~stk) ? SZ_32 : SZ_64;
		else if (stk)
			asz = ctrl_q[CTL_SSB] ? SZ_32 : SZ_16;
		else
			asz = (csd ^ p67) ? SZ_32 : SZ_16;
	end

	// ========================================
	// segment base and displacement
	wire seg_fs = (seg == SEG_FS);
	wire seg_gs = (seg == SEG_GS);
	wire seg_nul = m64 & (seg == SEG_ES || seg == SEG_CS ||
		seg == SEG_SS || seg == SEG_DS);
	wire seg_on = (seg != 3'h0) & ~seg_nul;
	wire [63:0] fsb = m64 ? fs_q : {32'h0, fs_q[31:0]};
	wire [63:0] gsb = m64 ? gs_q : {32'h0, gs_q[31:0]};
	wire [63:0] segb = seg_fs ? fsb : seg_gs ? gsb : 64'h0;
	wire [63:0] disp = (m64 & dec_q[DEC_MOV]) ? {dhi_q, dlo_q} :
		{{32{dlo_q[31]}}, dlo_q};
	wire [63:0] base = m64 ? gpr_q[bix] : {32'h0, gpr_q[bix][31:0]};
	wire [63:0] ea;
	lma_agen u_agen (
		.base_i     (base),
		.ip_i       (ip_q),
		.disp_i     (disp),
		.ip_rel_i   (m64 & dec_q[DEC_RIPR]),
		.asz_i      (asz),
		.seg_base_i (segb),
		.ea_o       (ea)
	);

	// ========================================
	// system register access rules
	wire s_cr   = (sel_q <= SYS_CR8);
	wire s_dr   = (sel_q[4:3] == SYS_DBG);
	wire s_xdr  = (sel_q[4:3] == SYS_XDBG);
	wire s_msr  = (sel_q == SYS_EXTENDED_FEATURE_REGISTER) | (sel_q == SYS_MEMORY_TYPE_RANGE_REG) |
		(sel_q == SYS_PMSR);
	wire s_ok   = (s_cr & ((sel_q != SYS_CR8) | m64)) | s_dr |
		s_msr;
	wire s_nar  = (s_cr | s_dr) & ~m64;
	wire [63:0] sraw = sys_q[sel_q];
	wire [63:0] pmask = (64'h1 << PADDR_W) - 64'h1;
	logic [63:0] sval;
	always_comb begin
		sval = sraw;
		if (sel_q == SYS_EXTENDED_FEATURE_REGISTER)
			sval[EXTENDED_FEATURE_REGISTER_LMA] = lma;
		if (sel_q == SYS_MEMORY_TYPE_RANGE_REG)
			sval = sraw & pmask;
		if (s_nar)
			sval[63:32] = 32'h0;
		if (!s_ok)
			sval = 64'h0;
	end

	// ========================================
	// axi write path
	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++)
			if (s[i]) r[8*i+:8] = n[8*i+:8];
		return r;
	endfunction
	wire [7:0] wa = awa_q[7:0];
	wire do_wr = aw_ok_q & w_ok_q & ~bv_q;
	wire we_ctl = do_wr & (wa == OFF_CTRL);
	wire we_dec = do_wr & (wa == OFF_DEC);
	wire we_wbg = do_wr & (wa == OFF_WBGO);
	wire we_iph = do_wr & (wa == OFF_IPH);
	wire we_sl  = do_wr & (wa == OFF_SYSL);
	wire [31:0] wm = merge(32'h0, wd_q, ws_q);
	wire w_map = (wa[1:0] == 2'h0) && (wa <= OFF_SYSH);
	wire [7:0] ra = S_AXI_ARADDR_I[7:0];
	wire r_map = (ra[1:0] == 2'h0) && (ra <= OFF_SYSH);
	wire [63:0] wbv = {wbh_q, wbl_q};
	wire [63:0] gr = gpr_q[rix];
	logic [63:0] wbn;
	always_comb begin
		unique case (osz)
			SZ_8:    wbn = {gr[63:8], wbv[7:0]};
			SZ_16:   wbn = {gr[63:16], wbv[15:0]};
			SZ_32:   wbn = {32'h0, wbv[31:0]};
			default: wbn = wbv;
		endcase
	end

	// ========================================
	// register file, one process per entry
	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : gen_gpr
			always_ff @(posedge SYS_CLK_I) begin
				if (RST_I)
					gpr_q[g] <= 64'h0;
				else if (we_wbg && rix == g)
					gpr_q[g] <= wbn;
			end
		end
		for (g = 0; g < 32; g++) begin : gen_sys
			always_ff @(posedge SYS_CLK_I) begin
				if (RST_I)
					sys_q[g] <= 64'h0;
				else if (we_sl && s_ok && sel_q == g)
					sys_q[g] <= s_nar ?
						{sys_q[g][63:32], merge(sys_q[g][31:0], wd_q,
						ws_q)} : {shi_q, merge(sys_q[g][31:0], wd_q,
						ws_q)};
			end
		end
	endgenerate

	// ========================================
	// software visible registers
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			ctrl_q <= RST_CTRL;
			dec_q  <= 32'h0;
			dlo_q  <= 32'h0;
			dhi_q  <= 32'h0;
			wbl_q  <= 32'h0;
			wbh_q  <= 32'h0;
			ip_q   <= 64'h0;
			flg_q  <= RST_FLAGS;
			fs_q   <= 64'h0;
			gs_q   <= 64'h0;
			sel_q  <= 5'h0;
			shi_q  <= 32'h0;
			err_q  <= 1'b0;
		end else if (do_wr) begin
			unique case (wa)
				OFF_CTRL:  ctrl_q <= merge(ctrl_q, wd_q, ws_q);
				OFF_DEC:   dec_q <= merge(dec_q, wd_q, ws_q);
				OFF_DISPL: dlo_q <= merge(dlo_q, wd_q, ws_q);
				OFF_DISPH: dhi_q <= merge(dhi_q, wd_q, ws_q);
				OFF_WBL:   wbl_q <= merge(wbl_q, wd_q, ws_q);
				OFF_WBH:   wbh_q <= merge(wbh_q, wd_q, ws_q);
				OFF_IPL:   ip_q[31:0] <= merge(ip_q[31:0], wd_q, ws_q);
				OFF_FLGL:  flg_q <= merge(flg_q, wd_q, ws_q);
				OFF_FSL:   fs_q[31:0] <= merge(fs_q[31:0], wd_q, ws_q);
				OFF_FSH:   fs_q[63:32] <= merge(fs_q[63:32], wd_q, ws_q);
				OFF_GSL:   gs_q[31:0] <= merge(gs_q[31:0], wd_q, ws_q);
				OFF_GSH:   gs_q[63:32] <= merge(gs_q[63:32], wd_q, ws_q);
				OFF_SSEL:  sel_q <= wm[4:0];
				OFF_SYSH:  shi_q <= merge(shi_q, wd_q, ws_q);
				OFF_SYSL:  err_q <= ~s_ok;
				default:   ;
			endcase
			if (we_iph && lma)
				ip_q[63:32] <= merge(ip_q[63:32], wd_q, ws_q);
		end
	end

	// ========================================
	// read mux
	wire [31:0] stat = {14'h0, err_q, bix, rix, seg_on, asz, osz,
		1'b0, lma, mode};
	logic [31:0] rmux;
	always_comb begin
		unique case (ra)
			OFF_CTRL:  rmux = ctrl_q;
			OFF_STAT:  rmux = stat;
			OFF_DEC:   rmux = dec_q;
			OFF_DISPL: rmux = dlo_q;
			OFF_DISPH: rmux = dhi_q;
			OFF_WBL:   rmux = wbl_q;
			OFF_WBH:   rmux = wbh_q;
			OFF_EAL:   rmux = ea[31:0];
			OFF_EAH:   rmux = ea[63:32];
			OFF_GPRL:  rmux = gr[31:0];
			OFF_GPRH:  rmux = m64 ? gr[63:32] : 32'h0;
			OFF_IPL:   rmux = ip_q[31:0];
			OFF_IPH:   rmux = lma ? ip_q[63:32] : 32'h0;
			OFF_FLGL:  rmux = flg_q;
			OFF_FLGH:  rmux = 32'h0;
			OFF_FSL:   rmux = fs_q[31:0];
			OFF_FSH:   rmux = fs_q[63:32];
			OFF_GSL:   rmux = gs_q[31:0];
			OFF_GSH:   rmux = gs_q[63:32];
			OFF_SSEL:  rmux = {27'h0, sel_q};
			OFF_SYSL:  rmux = sval[31:0];
			OFF_SYSH:  rmux = sval[63:32];
			default:   rmux = 32'h0;
		endcase
	end

	// ========================================
	// axi handshakes
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			awr_q   <= 1'b1;
			wr_q    <= 1'b1;
			aw_ok_q <= 1'b0;
			w_ok_q  <= 1'b0;
			awa_q   <= '0;
			wd_q    <= 32'h0;
			ws_q    <= 4'h0;
			bv_q    <= 1'b0;
			br_q    <= RESP_OKAY;
		end else begin
			if (awr_q && S_AXI_AWVALID_I) begin
				awr_q   <= 1'b0;
				aw_ok_q <= 1'b1;
				awa_q   <= S_AXI_AWADDR_I;
			end
			if (wr_q && S_AXI_WVALID_I) begin
				wr_q   <= 1'b0;
				w_ok_q <= 1'b1;
				wd_q   <= S_AXI_WDATA_I;
				ws_q   <= S_AXI_WSTRB_I;
			end
			if (do_wr) begin
				aw_ok_q <= 1'b0;
				w_ok_q  <= 1'b0;
				bv_q    <= 1'b1;
				br_q    <= w_map ? RESP_OKAY : RESP_SLVERR;
			end
			if (bv_q && S_AXI_BREADY_I) begin
				bv_q  <= 1'b0;
				awr_q <= 1'b1;
				wr_q  <= 1'b1;
			end
		end
	end
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			arr_q  <= 1'b1;
			rv_q   <= 1'b0;
			rd_q   <= 32'h0;
			rr_q   <= RESP_OKAY;
			mode_q <= MODE_LEGACY;
			lma_q  <= 1'b0;
		end else begin
			mode_q <= mode;
			lma_q  <= lma;
			if (arr_q && S_AXI_ARVALID_I) begin
				arr_q <= 1'b0;
				rv_q  <= 1'b1;
				rd_q  <= r_map ? rmux : 32'h0;
				rr_q  <= r_map ? RESP_OKAY : RESP_SLVERR;
			end else if (rv_q && S_AXI_RREADY_I) begin
				rv_q  <= 1'b0;
				arr_q <= 1'b1;
			end
		end
	end

	assign S_AXI_AWREADY_O = awr_q;
	assign S_AXI_WREADY_O  = wr_q;
	assign S_AXI_BVALID_O  = bv_q;
	assign S_AXI_BRESP_O   = br_q;
	assign S_AXI_ARREADY_O = arr_q;
	assign S_AXI_RVALID_O  = rv_q;
	assign S_AXI_RDATA_O   = rd_q;
	assign S_AXI_RRESP_O   = rr_q;
	assign MODE_O          = mode_q;
	assign LMA_O           = lma_q;
endmodule

// ===== testbench/lma_core_properties.sv
// port checker for the long-mode addressing core
`timescale 1ns/1ps
module lma_core_chk
	import lma_pkg::*;
#(
	parameter int AXI_AW  = 8,
	parameter int PADDR_W = 52
)(
	// clock, reset and bus
	input wire logic              SYS_CLK_I,
	input wire logic              RST_I,
	input wire logic [AXI_AW-1:0] S_AXI_AWADDR_I,
	input wire logic              S_AXI_AWVALID_I,
	input wire logic              S_AXI_AWREADY_O,
	input wire logic [31:0]       S_AXI_WDATA_I,
	input wire logic [3:0]        S_AXI_WSTRB_I,
	input wire logic              S_AXI_WVALID_I,
	input wire logic              S_AXI_WREADY_O,
	input wire logic [1:0]        S_AXI_BRESP_O,
	input wire logic              S_AXI_BVALID_O,
	input wire logic              S_AXI_BREADY_I,
	input wire logic [AXI_AW-1:0] S_AXI_ARADDR_I,
	input wire logic              S_AXI_ARVALID_I,
	input wire logic              S_AXI_ARREADY_O,
	input wire logic [31:0]       S_AXI_RDATA_O,
	input wire logic [1:0]        S_AXI_RRESP_O,
	input wire logic              S_AXI_RVALID_O,
	input wire logic              S_AXI_RREADY_I,
	// mode
	input wire lma_mode_t         MODE_O,
	input wire logic              LMA_O
);
	// ========================================
	// system select tracking
	logic [4:0]      sel_q;
	wire logic [7:0] ar_a  = S_AXI_ARADDR_I[7:0];
	wire logic       ar_hs = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
	wire logic       sel_w = S_AXI_AWVALID_I && S_AXI_AWREADY_O
		&& S_AXI_WVALID_I && S_AXI_WREADY_O
		&& S_AXI_AWADDR_I[7:0] == OFF_SSEL;
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			sel_q <= 5'h00;
		end else if (sel_w) begin
			sel_q <= S_AXI_WDATA_I[4:0];
		end
	end
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (RST_I);
	// ========================================
	// assertions
	flags_high_zero_a: assert property (
		ar_hs && ar_a == OFF_FLGH |=> S_AXI_RDATA_O == 32'h0)
		else $error("flags upper word not zero");
	gpr_high_zero_a: assert property (
		ar_hs && ar_a == OFF_GPRH && MODE_O != MODE_64
		|=> S_AXI_RDATA_O == 32'h0)
		else $error("register upper word visible outside 64-bit");
	mode_lma_tie_a: assert property (
		LMA_O == (MODE_O != MODE_LEGACY))
		else $error("mode and long-mode flag disagree");
	status_mode_a: assert property (
		ar_hs && ar_a == OFF_STAT |=> S_AXI_RDATA_O[1:0] == MODE_O
		&& S_AXI_RDATA_O[ST_LMA] == LMA_O)
		else $error("status mode differs from mode port");
	lma_by_write_a: assert property (
		$changed(LMA_O) |-> S_AXI_BVALID_O || $past(S_AXI_BVALID_O))
		else $error("long-mode flag moved without a write");
	mode_by_write_a: assert property (
		$changed(MODE_O) |-> S_AXI_BVALID_O || $past(S_AXI_BVALID_O))
		else $error("mode moved without a write");
	ctl_high_hidden_a: assert property (
		ar_hs && ar_a == OFF_SYSH && MODE_O != MODE_64
		&& (sel_q <= 5'h08 || sel_q[4:3] == SYS_DBG)
		|=> S_AXI_RDATA_O == 32'h0)
		else $error("control upper word visible outside 64-bit");
	xdbg_refused_a: assert property (
		ar_hs && ar_a == OFF_SYSL && sel_q[4:3] == SYS_XDBG
		|=> S_AXI_RDATA_O == 32'h0)
		else $error("extended debug register readable");
	extended_feature_register_active_a: assert property (
		ar_hs && ar_a == OFF_SYSL && sel_q == SYS_EXTENDED_FEATURE_REGISTER
		|=> S_AXI_RDATA_O[EXTENDED_FEATURE_REGISTER_LMA] == LMA_O)
		else $error("active bit differs from long-mode flag");
	cover property (MODE_O == MODE_64);
	cover property (ar_hs && ar_a == OFF_STAT);
	cover property (S_AXI_BVALID_O && S_AXI_BRESP_O == RESP_SLVERR);
endmodule
bind lma_core lma_core_chk #(.AXI_AW(AXI_AW), .PADDR_W(PADDR_W)) u_chk (.*);

// ===== testbench/testbench.sv
// self-checking bench for the long-mode addressing core
`timescale 1ns/1ps
module testbench
	import lma_pkg::*;
;
	localparam logic [63:0] PA_M = (64'h1 << 52) - 64'h1;
	logic             clk = 1'b0;
	logic             rst = 1'b1;
	logic             awv = 1'b0;
	logic             wv  = 1'b0;
	logic             arv = 1'b0;
	logic [7:0]       awa = 8'h00;
	logic [7:0]       ara = 8'h00;
	logic [31:0]      wd  = 32'h0;
	logic [31:0]      seed = 32'h04f9;
	logic [1:0]       resp;
	wire logic        awr, wrd, bv, arr, rv, lma;
	wire logic [1:0]  br, rr;
	wire logic [31:0] rdat;
	wire lma_mode_t   mode;
	int               n_mismatch = 0;
	int               comparisons = 0;
	lma_core #(.PADDR_W(52)) uut (
		.SYS_CLK_I(clk), .RST_I(rst),
		.S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
		.S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv),
		.S_AXI_WREADY_O(wrd), .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv),
		.S_AXI_BREADY_I(1'b1), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
		.S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rr),
		.S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(1'b1), .MODE_O(mode), .LMA_O(lma)
	);
	always #2 clk = ~clk;
	// ========================================
	// helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [95:0] got, input logic [95:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		do begin
			@(posedge clk);
			if (awr === 1'b1) awv <= 1'b0;
			if (wrd === 1'b1) wv <= 1'b0;
		end while (bv !== 1'b1);
		resp = br;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		ara <= a;
		arv <= 1'b1;
		do begin
			@(posedge clk);
			if (arr === 1'b1) arv <= 1'b0;
		end while (rv !== 1'b1);
		d = rdat;
		resp = rr;
	endtask
	task automatic wr64(input logic [7:0] a, input logic [63:0] v);
		wr(a + 8'h04, v[63:32]);
		wr(a, v[31:0]);
	endtask
	task automatic rd64(input logic [7:0] a, output logic [63:0] v);
		rd(a, v[31:0]);
		rd(a + 8'h04, v[63:32]);
	endtask
	task automatic sysw(input logic [4:0] s, input logic [63:0] v);
		wr(OFF_SSEL, {27'h0, s});
		wr64(OFF_SYSL, v);
	endtask
	task automatic sysr(input logic [4:0] s, output logic [63:0] v);
		wr(OFF_SSEL, {27'h0, s});
		rd64(OFF_SYSL, v);
	endtask
	task automatic gpw(input logic [31:0] dw, input logic [63:0] v);
		wr(OFF_DEC, dw);
		wr64(OFF_WBL, v);
		wr(OFF_WBGO, 32'h0);
	endtask
	function automatic logic [15:0] exp_st(input logic [31:0] dw,
			input lma_mode_t m);
		logic      l, x, s;
		lma_size_t o, a;
		l = m == MODE_64;
		x = l & dw[DEC_REXP];
		s = dw[8:6] == SEG_FS || dw[8:6] == SEG_GS || (!l && dw[8:6] != 3'h0);
		if (x & dw[DEC_REXW]) o = SZ_64;
		else if (dw[DEC_OPSZ]) o = SZ_16;
		else if (l & (dw[DEC_STK] | dw[DEC_NEAR]) & !dw[DEC_FAR]) o = SZ_64;
		else o = SZ_32;
		if (l) a = (dw[DEC_ADSZ] & !dw[DEC_STK]) ? SZ_32 : SZ_64;
		else a = dw[DEC_ADSZ] ? SZ_16 : SZ_32;
		return {dw[DEC_STK] ? SP_IDX : {x & dw[DEC_REXB], dw[20:18]},
			x & dw[DEC_REXR], dw[17:15], s, a, o, m != MODE_LEGACY, m};
	endfunction
	task print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// ========================================
	// scenarios
	initial begin
		logic [63:0] v, e, g, ip, x, s, ex;
		logic [31:0] r, dw, d, dh;
		logic [31:0] dws [7] = '{32'h1000, 32'h1020, 32'h1100, 32'h1140,
			32'h1180, 32'h2000, 32'h0220};
		lma_mode_t   m;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(OFF_FLGL, r);
		chk(r, RST_FLAGS);
		wr(OFF_FLGH, 32'hffff_ffff);
		rd(OFF_FLGH, r);
		chk(r, 32'h0);
		rd(8'h5c, r);
		chk({resp, r}, {RESP_SLVERR, 32'h0});
		wr(8'h5e, 32'h1);
		chk(resp, RESP_SLVERR);
		for (int i = 0; i < 4; i++) begin
			m = i == 3 ? MODE_LEGACY : lma_mode_t'(i);
			sysw(SYS_EXTENDED_FEATURE_REGISTER, 64'h1 << EXTENDED_FEATURE_REGISTER_LME);
			sysw(SYS_CR0, {32'h0, m != MODE_LEGACY, 31'h0});
			wr(OFF_CTRL, {30'h0, 1'b1, m == MODE_64});
			sysr(SYS_EXTENDED_FEATURE_REGISTER, v);
			chk({v[EXTENDED_FEATURE_REGISTER_LMA], lma, mode}, {m != MODE_LEGACY,
				m != MODE_LEGACY, m});
			repeat (10) begin
				dw = rnd() & (m == MODE_64 ? 32'h1f8fff : 32'h1f8dff);
				if (dw[8:6] == 3'h7) dw[8:6] = 3'h0;
				if (dw[DEC_NEAR]) dw[DEC_FAR] = 1'b0;
				wr(OFF_DEC, dw);
				rd(OFF_STAT, r);
				chk({r[16:4], r[2:0]}, exp_st(dw, m));
			end
			v = {rnd(), rnd()};
			sysw(5'h03, v);
			sysr(5'h03, e);
			chk(e, {m == MODE_64 ? v[63:32] : 32'h0, v[31:0]});
			sysw(SYS_CR8, v);
			rd(OFF_STAT, r);
			chk(r[ST_ERR], m != MODE_64);
			sysw(5'h18, v);
			rd(OFF_STAT, r);
			sysr(5'h18, e);
			chk({r[ST_ERR], e}, {1'b1, 64'h0});
			sysw(SYS_MEMORY_TYPE_RANGE_REG, '1);
			sysr(SYS_MEMORY_TYPE_RANGE_REG, e);
			chk(e, PA_M);
			sysw(SYS_PMSR, v & PA_M);
			sysr(SYS_PMSR, e);
			chk(e, v & PA_M);
			wr64(OFF_IPL, v);
			rd64(OFF_IPL, e);
			chk(e, {m != MODE_LEGACY ? v[63:32] : 32'h0, v[31:0]});
			gpw(32'h10003, v);
			rd64(OFF_GPRL, e);
			chk(e, {m == MODE_64 ? v[63:32] : 32'h0, v[31:0]});
			if (m == MODE_64) begin
				e = {rnd(), rnd()};
				g = {rnd(), rnd()};
				gpw(32'h8003, v);
				gpw(32'h8010, e);
				rd64(OFF_GPRL, x);
				chk(x, {v[63:16], e[15:0]});
				gpw(32'h8000, e);
				rd64(OFF_GPRL, x);
				chk(x, {32'h0, e[31:0]});
				gpw(32'h8007, g);
				rd64(OFF_GPRL, x);
				chk(x, g);
				gpw(32'h20003, g);
				ip = {rnd(), rnd()};
				wr64(OFF_IPL, ip);
				wr64(OFF_FSL, v);
				wr64(OFF_GSL, e);
				d = rnd() | 32'h8000_0000;
				dh = rnd();
				wr(OFF_DISPL, d);
				wr(OFF_DISPH, dh);
				s = ip + {{32{d[31]}}, d};
				for (int k = 0; k < 7; k++) begin
					wr(OFF_DEC, dws[k]);
					rd64(OFF_EAL, x);
					case (k)
						1: ex = {32'h0, s[31:0]};
						3: ex = s + v;
						4: ex = s + e;
						5: ex = {dh, d};
						6: ex = g + {{32{d[31]}}, d};
						default: ex = s;
					endcase
					chk(x, ex);
				end
			end
		end
		print_verdict();
	end
	initial begin
		#100000;
		n_mismatch++;
		print_verdict();
	end
endmodule
